// ===== rtl/brk_pkg.sv
package brk_pkg;

    localparam int ADDR_W = 32;
    localparam int MSR_W = 32;

    // Machine state bit positions, bit 0 is the least significant
    localparam int MSR_ILE = 16;
    localparam int MSR_ME = 12;
    localparam int MSR_IP = 6;
    localparam int MSR_RI = 1;
    localparam int MSR_LE = 0;

    localparam logic [ADDR_W-1:0] VEC_BASE_LOW = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] VEC_BASE_HIGH = 32'hFFF0_0000;
    localparam logic [ADDR_W-1:0] OFF_NMI = 32'h0000_1000;
    localparam logic [ADDR_W-1:0] OFF_DATA = 32'h0000_1C00;
    localparam logic [ADDR_W-1:0] OFF_INSN = 32'h0000_1D00;
    localparam logic [ADDR_W-1:0] OFF_MASK = 32'h0000_1E00;

    localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
    localparam logic [MSR_W-1:0] MSR_RST = 32'h0000_0000;

    typedef enum logic [2:0] {SRC_NONE, SRC_NMI, SRC_DATA, SRC_INSN, SRC_MASK} brk_src_e;
    typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_DEBUG} exc_state_e;

    function automatic logic [MSR_W-1:0] entry_msr(input logic [MSR_W-1:0] machine_state_reg);
        logic [MSR_W-1:0] r;
        r = '0;
        r[MSR_IP] = machine_state_reg[MSR_IP];
        r[MSR_ME] = machine_state_reg[MSR_ME];
        r[MSR_LE] = machine_state_reg[MSR_ILE];
        return r;
    endfunction : entry_msr

    function automatic logic [MSR_W-1:0] saved_state(input logic [MSR_W-1:0] machine_state_reg);
        return {16'h0000, machine_state_reg[15:0]};
    endfunction : saved_state

    function automatic logic [ADDR_W-1:0] vector_fetch(input logic [MSR_W-1:0] machine_state_reg,
                                                       input logic [ADDR_W-1:0] off);
        return (machine_state_reg[MSR_IP] ? VEC_BASE_HIGH : VEC_BASE_LOW) | off;
    endfunction : vector_fetch

endpackage : brk_pkg

// ===== rtl/brk_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module brk_sync2 #(
    parameter int WIDTH = 3
) (
    input wire logic clk_in,
    input wire logic ce_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    // Two stages; first stage feeds only the second
    always_comb begin
        meta_next = ce_in ? async_in : meta_reg;
        sync_next = ce_in ? meta_reg : sync_reg;
    end

    always_ff @(posedge clk_in) begin
        meta_reg <= meta_next;
        sync_reg <= sync_next;
    end

    assign sync_out = sync_reg;
endmodule : brk_sync2
`default_nettype wire

// ===== rtl/brk_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module brk_arbiter (
    input wire logic nmi_in,
    input wire logic data_in,
    input wire logic insn_in,
    input wire logic mask_in,
    output brk_pkg::brk_src_e src_out,
    output logic [brk_pkg::ADDR_W-1:0] offset_out
);
    import brk_pkg::*;

    // Fixed priority, one winner
    always_comb begin
        if (nmi_in) begin
            src_out = SRC_NMI;
            offset_out = OFF_NMI;
        end else if (data_in) begin
            src_out = SRC_DATA;
            offset_out = OFF_DATA;
        end else if (insn_in) begin
            src_out = SRC_INSN;
            offset_out = OFF_INSN;
        end else if (mask_in) begin
            src_out = SRC_MASK;
            offset_out = OFF_MASK;
        end else begin
            src_out = SRC_NONE;
            offset_out = ADDR_RST;
        end
    end
endmodule : brk_arbiter
`default_nettype wire

// ===== rtl/brk_exception_unit.sv
`timescale 1ns/1ps
`default_nettype none
module brk_exception_unit (
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic CE_IN,
    input wire logic MASKED_MODE_IN,
    input wire logic [brk_pkg::MSR_W-1:0] MSR_IN,
    input wire logic DATA_MATCH_IN,
    input wire logic [brk_pkg::ADDR_W-1:0] DATA_EA_IN,
    input wire logic [brk_pkg::ADDR_W-1:0] DATA_NEXT_PC_IN,
    input wire logic INSN_MATCH_IN,
    input wire logic [brk_pkg::ADDR_W-1:0] INSN_PC_IN,
    input wire logic BOUNDARY_IN,
    input wire logic [brk_pkg::ADDR_W-1:0] BOUNDARY_PC_IN,
    input wire logic MASK_BRK_REQ_IN,
    input wire logic NMI_BRK_REQ_IN,
    input wire logic DBG_PORT_REQ_IN,
    input wire logic HALTED_IN,
    input wire logic [brk_pkg::ADDR_W-1:0] NEXT_PC_IN,
    input wire logic DEBUG_EN_IN,
    input wire logic DEBUG_EXIT_IN,
    input wire logic NONRESTART_CLR_IN,
    output logic TAKE_OUT,
    output brk_pkg::brk_src_e CAUSE_OUT,
    output logic [brk_pkg::ADDR_W-1:0] FETCH_ADDR_OUT,
    output logic [brk_pkg::ADDR_W-1:0] SAVED_PC_OUT,
    output logic [brk_pkg::MSR_W-1:0] SAVED_STATE_OUT,
    output logic [brk_pkg::MSR_W-1:0] MSR_NEW_OUT,
    output logic [brk_pkg::ADDR_W-1:0] BRK_ADDR_OUT,
    output logic HALT_OUT,
    output logic DEBUG_MODE_OUT,
    output logic NONRESTART_OUT,
    output logic SAVE_UNDEF_OUT
);
    import brk_pkg::*;

    logic [2:0] sync_w;
    logic nmi_sync;
    logic mask_sync;
    logic dbg_sync;
    logic ri;
    logic data_hit;
    logic insn_hit;
    logic nmi_rise;
    logic mask_ok;
    brk_src_e win_src;
    logic [ADDR_W-1:0] win_off;
    logic [2:0] async_w;
    logic run_gate;

    exc_state_e state_reg, state_next;
    logic nmi_prev_reg, nmi_prev_next;
    logic nmi_pend_reg, nmi_pend_next;
    logic data_pend_reg, data_pend_next;
    logic insn_pend_reg, insn_pend_next;
    logic [ADDR_W-1:0] data_pc_reg, data_pc_next;
    logic [ADDR_W-1:0] insn_pc_reg, insn_pc_next;
    logic [ADDR_W-1:0] brk_addr_reg, brk_addr_next;
    logic take_reg, take_next;
    brk_src_e cause_reg, cause_next;
    logic [ADDR_W-1:0] fetch_reg, fetch_next;
    logic [ADDR_W-1:0] saved_pc_reg, saved_pc_next;
    logic [MSR_W-1:0] saved_state_reg, saved_state_next;
    logic [MSR_W-1:0] msr_new_reg, msr_new_next;
    logic halt_reg, halt_next;
    logic debug_reg, debug_next;
    logic nonrestart_reg, nonrestart_next;
    logic strap_reg, strap_next;

    // Pin requests, packed for the synchroniser
    assign async_w = {DBG_PORT_REQ_IN, MASK_BRK_REQ_IN, NMI_BRK_REQ_IN};

    brk_sync2 #(
        .WIDTH(3)
    ) u_sync (
        .clk_in(CLK_IN),
        .ce_in(CE_IN),
        .async_in(async_w),
        .sync_out(sync_w)
    );

    assign nmi_sync = sync_w[0];
    assign mask_sync = sync_w[1];
    assign dbg_sync = sync_w[2];

    // Match recognition, shared by the data and instruction comparators
    function automatic logic match_ok(input logic match, input logic masked, input logic rec);
        return match & (~masked | rec);
    endfunction : match_ok

    // Recognition of internal matches
    assign ri = MSR_IN[MSR_RI];
    assign data_hit = match_ok(DATA_MATCH_IN, MASKED_MODE_IN, ri);
    assign insn_hit = match_ok(INSN_MATCH_IN, MASKED_MODE_IN, ri);
    assign nmi_rise = nmi_sync & ~nmi_prev_reg;
    // Data, instruction and maskable entries happen only at an instruction boundary while running
    assign run_gate = BOUNDARY_IN & (state_reg == ST_RUN);
    // Maskable request only while recoverable
    assign mask_ok = mask_sync & ri & run_gate;

    brk_arbiter u_arb (
        .nmi_in(nmi_pend_reg & (state_reg == ST_RUN)),
        .data_in(data_pend_reg & run_gate),
        .insn_in(insn_pend_reg & run_gate),
        .mask_in(mask_ok),
        .src_out(win_src),
        .offset_out(win_off)
    );

    // Pending breakpoints and captured addresses
    always_comb begin
        nmi_prev_next = nmi_sync;
        nmi_pend_next = nmi_pend_reg;
        data_pend_next = data_pend_reg;
        insn_pend_next = insn_pend_reg;
        data_pc_next = data_pc_reg;
        insn_pc_next = insn_pc_reg;
        brk_addr_next = brk_addr_reg;
        if (state_reg == ST_HALT && HALTED_IN) begin
            nmi_pend_next = 1'b0;
        end
        if (take_next && win_src == SRC_DATA) begin
            data_pend_next = 1'b0;
        end
        if (take_next && win_src == SRC_INSN) begin
            insn_pend_next = 1'b0;
        end
        // A new non-maskable event wins over the clear in the same cycle; a data or instruction match is dropped while one is pending
        if (nmi_rise) begin
            nmi_pend_next = 1'b1;
        end
        if (data_hit && !data_pend_reg) begin
            data_pend_next = 1'b1;
            data_pc_next = DATA_NEXT_PC_IN;
            brk_addr_next = DATA_EA_IN;
        end
        if (insn_hit && !insn_pend_reg) begin
            insn_pend_next = 1'b1;
            insn_pc_next = INSN_PC_IN;
        end
    end

    // Exception entry sequencing
    always_comb begin
        state_next = state_reg;
        take_next = 1'b0;
        cause_next = cause_reg;
        fetch_next = fetch_reg;
        saved_pc_next = saved_pc_reg;
        saved_state_next = saved_state_reg;
        msr_new_next = msr_new_reg;
        halt_next = halt_reg;
        debug_next = debug_reg;
        case (state_reg)
            ST_RUN: begin
                if (nmi_pend_reg) begin
                    // Stop at once, whatever the recoverable flag
                    state_next = ST_HALT;
                    halt_next = 1'b1;
                end else if (win_src != SRC_NONE) begin
                    take_next = 1'b1;
                    cause_next = win_src;
                    fetch_next = vector_fetch(MSR_IN, win_off);
                    saved_state_next = saved_state(MSR_IN);
                    msr_new_next = entry_msr(MSR_IN);
                    case (win_src)
                        SRC_DATA: saved_pc_next = data_pc_reg;
                        SRC_INSN: saved_pc_next = insn_pc_reg;
                        default: saved_pc_next = BOUNDARY_PC_IN;
                    endcase
                end
            end
            ST_HALT: begin
                if (HALTED_IN) begin
                    if (DEBUG_EN_IN) begin
                        state_next = ST_DEBUG;
                        debug_next = 1'b1;
                    end else begin
                        state_next = ST_RUN;
                        halt_next = 1'b0;
                        take_next = 1'b1;
                        cause_next = SRC_NMI;
                        fetch_next = vector_fetch(MSR_IN, OFF_NMI);
                        saved_pc_next = NEXT_PC_IN;
                        saved_state_next = saved_state(MSR_IN);
                        msr_new_next = entry_msr(MSR_IN);
                    end
                end
            end
            ST_DEBUG: begin
                if (DEBUG_EXIT_IN) begin
                    state_next = ST_RUN;
                    halt_next = 1'b0;
                    debug_next = 1'b0;
                end
            end
            default: begin
                state_next = ST_RUN;
                halt_next = 1'b0;
                debug_next = 1'b0;
            end
        endcase
    end

    // Non-restartable flag; a setting event wins over the clear
    always_comb begin
        nonrestart_next = nonrestart_reg;
        if (NONRESTART_CLR_IN) begin
            nonrestart_next = 1'b0;
        end
        // Unrecoverable recognition in non-masked mode
        if (!MASKED_MODE_IN && !ri && (DATA_MATCH_IN || INSN_MATCH_IN)) begin
            nonrestart_next = 1'b1;
        end
        // Stop reached while unrecoverable
        if (state_reg == ST_HALT && HALTED_IN && !ri) begin
            nonrestart_next = 1'b1;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            nonrestart_reg <= 1'b0;
        end else if (CE_IN) begin
            nonrestart_reg <= nonrestart_next;
        end
    end

    // Strap level holds between resets
    always_comb begin
        strap_next = strap_reg;
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            strap_reg <= dbg_sync;
        end else if (CE_IN) begin
            strap_reg <= strap_next;
        end
    end

    // Pending requests and captured addresses
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            nmi_prev_reg <= 1'b0;
            nmi_pend_reg <= 1'b0;
            data_pend_reg <= 1'b0;
            insn_pend_reg <= 1'b0;
            data_pc_reg <= ADDR_RST;
            insn_pc_reg <= ADDR_RST;
            brk_addr_reg <= ADDR_RST;
        end else if (CE_IN) begin
            nmi_prev_reg <= nmi_prev_next;
            nmi_pend_reg <= nmi_pend_next;
            data_pend_reg <= data_pend_next;
            insn_pend_reg <= insn_pend_next;
            data_pc_reg <= data_pc_next;
            insn_pc_reg <= insn_pc_next;
            brk_addr_reg <= brk_addr_next;
        end
    end

    // Entry state and saved values
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            state_reg <= ST_RUN;
            take_reg <= 1'b0;
            cause_reg <= SRC_NONE;
            fetch_reg <= ADDR_RST;
            saved_pc_reg <= ADDR_RST;
            saved_state_reg <= MSR_RST;
            msr_new_reg <= MSR_RST;
            halt_reg <= 1'b0;
            debug_reg <= 1'b0;
        end else if (CE_IN) begin
            state_reg <= state_next;
            take_reg <= take_next;
            cause_reg <= cause_next;
            fetch_reg <= fetch_next;
            saved_pc_reg <= saved_pc_next;
            saved_state_reg <= saved_state_next;
            msr_new_reg <= msr_new_next;
            halt_reg <= halt_next;
            debug_reg <= debug_next;
        end
    end

    // Fault address, cause and the other outputs are registered in this block and driven straight out
    assign TAKE_OUT = take_reg;
    assign CAUSE_OUT = cause_reg;
    assign FETCH_ADDR_OUT = fetch_reg;
    assign SAVED_PC_OUT = saved_pc_reg;
    assign SAVED_STATE_OUT = saved_state_reg;
    assign MSR_NEW_OUT = msr_new_reg;
    assign BRK_ADDR_OUT = brk_addr_reg;
    assign HALT_OUT = halt_reg;
    assign DEBUG_MODE_OUT = debug_reg;
    assign NONRESTART_OUT = nonrestart_reg;
    assign SAVE_UNDEF_OUT = strap_reg;
endmodule : brk_exception_unit
`default_nettype wire

// ===== sim/brk_exception_props.sv
`timescale 1ns/1ps
`default_nettype none
module brk_exception_props (
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic CE_IN,
    input wire logic [brk_pkg::MSR_W-1:0] MSR_IN,
    input wire logic NMI_BRK_REQ_IN,
    input wire logic HALTED_IN,
    input wire logic DEBUG_EN_IN,
    input wire logic TAKE_OUT,
    input wire brk_pkg::brk_src_e CAUSE_OUT,
    input wire logic [brk_pkg::ADDR_W-1:0] FETCH_ADDR_OUT,
    input wire logic [brk_pkg::MSR_W-1:0] SAVED_STATE_OUT,
    input wire logic [brk_pkg::MSR_W-1:0] MSR_NEW_OUT,
    input wire logic HALT_OUT,
    input wire logic DEBUG_MODE_OUT,
    input wire logic NONRESTART_OUT
);
    import brk_pkg::*;
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);
    function automatic logic [31:0] vb(input logic [31:0] m);
        return m[MSR_IP] ? VEC_BASE_HIGH : VEC_BASE_LOW;
    endfunction : vb
    // Rising edge of the unsynchronised non-maskable request, then three enabled cycles
    sequence nmi_seen;
        $rose(NMI_BRK_REQ_IN) && !HALT_OUT && !DEBUG_MODE_OUT ##1 CE_IN [*3];
    endsequence
    // Sequencer reports the stop while no debug entry is wanted
    sequence halt_done;
        HALT_OUT && !DEBUG_MODE_OUT && HALTED_IN && !DEBUG_EN_IN && CE_IN;
    endsequence
    chk_data_vector: assert property (TAKE_OUT && CAUSE_OUT == SRC_DATA |->
        FETCH_ADDR_OUT == (vb($past(MSR_IN)) | 32'h0000_1C00)) else $error("data vector wrong");
    chk_insn_vector: assert property (TAKE_OUT && CAUSE_OUT == SRC_INSN |->
        FETCH_ADDR_OUT == (vb($past(MSR_IN)) | 32'h0000_1D00)) else $error("insn vector wrong");
    chk_mask_vector: assert property (TAKE_OUT && CAUSE_OUT == SRC_MASK |->
        FETCH_ADDR_OUT == (vb($past(MSR_IN)) | 32'h0000_1E00)) else $error("mask vector wrong");
    chk_nmi_vector: assert property (TAKE_OUT && CAUSE_OUT == SRC_NMI |->
        FETCH_ADDR_OUT == (vb($past(MSR_IN)) | 32'h0000_1000)) else $error("nmi vector wrong");
    chk_state_save: assert property (TAKE_OUT |->
        SAVED_STATE_OUT == {16'h0000, $past(MSR_IN[15:0])}) else $error("saved state wrong");
    chk_msr_entry: assert property (TAKE_OUT |-> MSR_NEW_OUT == {19'h00000,
        $past(MSR_IN[MSR_ME]), 5'h00, $past(MSR_IN[MSR_IP]), 5'h00, $past(MSR_IN[MSR_ILE])})
        else $error("entry machine state wrong");
    chk_mask_needs_ri: assert property (TAKE_OUT && CAUSE_OUT == SRC_MASK |->
        $past(MSR_IN[MSR_RI])) else $error("maskable taken while unrecoverable");
    chk_nmi_halt_time: assert property (nmi_seen |=> HALT_OUT)
        else $error("halt not raised in time");
    chk_nmi_take_exit: assert property (halt_done |=>
        TAKE_OUT && !HALT_OUT && CAUSE_OUT == SRC_NMI) else $error("nmi entry wrong");
    chk_nmi_unrecov: assert property (halt_done |=>
        NONRESTART_OUT || $past(MSR_IN[MSR_RI])) else $error("unrecoverable stop not flagged");
endmodule : brk_exception_props
bind brk_exception_unit brk_exception_props u_brk_exception_props (
    .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .CE_IN(CE_IN), .MSR_IN(MSR_IN),
    .NMI_BRK_REQ_IN(NMI_BRK_REQ_IN), .HALTED_IN(HALTED_IN), .DEBUG_EN_IN(DEBUG_EN_IN),
    .TAKE_OUT(TAKE_OUT), .CAUSE_OUT(CAUSE_OUT), .FETCH_ADDR_OUT(FETCH_ADDR_OUT),
    .SAVED_STATE_OUT(SAVED_STATE_OUT), .MSR_NEW_OUT(MSR_NEW_OUT), .HALT_OUT(HALT_OUT),
    .DEBUG_MODE_OUT(DEBUG_MODE_OUT), .NONRESTART_OUT(NONRESTART_OUT)
);
`default_nettype wire

// ===== sim/brk_dev_side_model.sv
`timescale 1ns/1ps
`default_nettype none
module brk_dev_side_model #(
    parameter logic [31:0] PC_VAL = 32'h0000_5A5C
) (
    input wire logic clk_in,
    input wire logic nmi_trap_in,
    input wire logic mask_trap_in,
    input wire logic halt_req_in,
    input wire logic [3:0] stall_in,
    output logic nmi_req_out,
    output logic mask_req_out,
    output logic halted_out,
    output logic [31:0] next_pc_out
);
    logic [3:0] wait_reg;
    always_ff @(posedge clk_in) begin
        nmi_req_out <= nmi_trap_in;
        mask_req_out <= mask_trap_in;
        wait_reg <= halt_req_in ? wait_reg + {3'h0, wait_reg != 4'hF} : 4'h0;
    end
    // Sequencer stops after a programmable stall
    assign halted_out = halt_req_in && (wait_reg >= stall_in);
    assign next_pc_out = halted_out ? PC_VAL : ~PC_VAL;
endmodule : brk_dev_side_model
`default_nettype wire

// ===== sim/brk_exception_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module brk_exception_unit_tb;
    import brk_pkg::*;
    logic clk, rst_n, masked, dmatch, imatch, nmi_trap, mask_trap, dbg_en, dbg_exit, nr_clr;
    logic dbg_req, nmi_req, mask_req, halted, take, halt, dmode, nonr, sundef;
    logic [31:0] machine_state_reg, dea, dnpc, ipc, bpc, npc, fetch, spc, sst, mnew, baddr;
    logic [3:0] stall;
    brk_src_e cause;
    int miscompares = 0;
    int num_checks = 0;
    brk_exception_unit u_brk_exception_unit (
        .CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(1'b1), .MASKED_MODE_IN(masked), .MSR_IN(machine_state_reg),
        .DATA_MATCH_IN(dmatch), .DATA_EA_IN(dea), .DATA_NEXT_PC_IN(dnpc),
        .INSN_MATCH_IN(imatch), .INSN_PC_IN(ipc), .BOUNDARY_IN(1'b1), .BOUNDARY_PC_IN(bpc),
        .MASK_BRK_REQ_IN(mask_req), .NMI_BRK_REQ_IN(nmi_req), .DBG_PORT_REQ_IN(dbg_req),
        .HALTED_IN(halted), .NEXT_PC_IN(npc), .DEBUG_EN_IN(dbg_en), .DEBUG_EXIT_IN(dbg_exit),
        .NONRESTART_CLR_IN(nr_clr), .TAKE_OUT(take), .CAUSE_OUT(cause), .FETCH_ADDR_OUT(fetch),
        .SAVED_PC_OUT(spc), .SAVED_STATE_OUT(sst), .MSR_NEW_OUT(mnew), .BRK_ADDR_OUT(baddr),
        .HALT_OUT(halt), .DEBUG_MODE_OUT(dmode), .NONRESTART_OUT(nonr), .SAVE_UNDEF_OUT(sundef)
    );
    brk_dev_side_model u_brk_dev_side_model (
        .clk_in(clk), .nmi_trap_in(nmi_trap), .mask_trap_in(mask_trap), .halt_req_in(halt),
        .stall_in(stall), .nmi_req_out(nmi_req), .mask_req_out(mask_req), .halted_out(halted),
        .next_pc_out(npc)
    );
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wait_take(input logic want);
        int n;
        n = 0;
        while (take !== 1'b1 && n < 12) begin
            tick();
            n++;
        end
        check("take", 32'(take), 32'(want));
    endtask : wait_take
    task automatic wait_halt();
        int n;
        n = 0;
        while (halt !== 1'b1 && n < 12) begin
            tick();
            n++;
        end
        check("halt", 32'(halt), 32'h1);
    endtask : wait_halt
    task automatic pulse_data();
        dmatch = 1'b1;
        tick();
        dmatch = 1'b0;
    endtask : pulse_data
    task automatic do_reset(input logic req);
        rst_n = 1'b0;
        dbg_req = req;
        repeat (5) tick();
        rst_n = 1'b1;
        dbg_req = 1'b0;
        tick();
        check("undef", 32'(sundef), 32'(req));
        check("take", 32'(take), 32'h0);
    endtask : do_reset
    task automatic t_data();
        machine_state_reg = 32'h0001_1003;
        dea = 32'h0000_8A54;
        dnpc = 32'h0000_2104;
        pulse_data();
        wait_take(1'b1);
        check("cause", 32'(cause), 32'(SRC_DATA));
        check("bar", baddr, 32'h0000_8A54);
        check("fetch", fetch, 32'h0000_1C00);
        check("spc", spc, 32'h0000_2104);
        check("sst", sst, 32'h0000_1003);
        check("msr", mnew, 32'h0000_1001);
        $display("TB: data breakpoint done");
    endtask : t_data
    task automatic t_insn_masked();
        masked = 1'b1;
        machine_state_reg = 32'h0001_1041;
        pulse_data();
        wait_take(1'b0);
        check("nonr", 32'(nonr), 32'h0);
        machine_state_reg = 32'h0001_1043;
        ipc = 32'h0000_7700;
        imatch = 1'b1;
        tick();
        imatch = 1'b0;
        wait_take(1'b1);
        check("cause", 32'(cause), 32'(SRC_INSN));
        check("fetch", fetch, 32'hFFF0_1D00);
        check("spc", spc, 32'h0000_7700);
        check("msr", mnew, 32'h0000_1041);
        masked = 1'b0;
        machine_state_reg = 32'h0001_1041;
        pulse_data();
        check("nonr", 32'(nonr), 32'h1);
        wait_take(1'b1);
        nr_clr = 1'b1;
        tick();
        nr_clr = 1'b0;
        check("nonr", 32'(nonr), 32'h0);
        $display("TB: instruction and masked mode done");
    endtask : t_insn_masked
    task automatic t_mask_ext();
        machine_state_reg = 32'h0001_1001;
        bpc = 32'h0000_4440;
        mask_trap = 1'b1;
        wait_take(1'b0);
        machine_state_reg = 32'h0001_1043;
        wait_take(1'b1);
        machine_state_reg = 32'h0000_1041;
        mask_trap = 1'b0;
        check("cause", 32'(cause), 32'(SRC_MASK));
        check("spc", spc, 32'h0000_4440);
        check("fetch", fetch, 32'hFFF0_1E00);
        repeat (4) tick();
        $display("TB: maskable external done");
    endtask : t_mask_ext
    task automatic t_nmi();
        machine_state_reg = 32'h0001_1001;
        stall = 4'h3;
        nmi_trap = 1'b1;
        wait_halt();
        nmi_trap = 1'b0;
        dnpc = 32'h0000_6000;
        pulse_data();
        nr_clr = 1'b1;
        tick();
        nr_clr = 1'b0;
        check("nonr", 32'(nonr), 32'h0);
        wait_take(1'b1);
        check("cause", 32'(cause), 32'(SRC_NMI));
        check("fetch", fetch, 32'h0000_1000);
        check("spc", spc, 32'h0000_5A5C);
        check("sst", sst, 32'h0000_1001);
        check("nonr", 32'(nonr), 32'h1);
        tick();
        wait_take(1'b1);
        check("cause", 32'(cause), 32'(SRC_DATA));
        $display("TB: non-maskable done");
    endtask : t_nmi
    task automatic t_debug();
        dbg_en = 1'b1;
        stall = 4'h0;
        nmi_trap = 1'b1;
        wait_halt();
        nmi_trap = 1'b0;
        repeat (2) tick();
        check("dmode", 32'({dmode, halt, take}), 32'h6);
        dbg_exit = 1'b1;
        tick();
        dbg_exit = 1'b0;
        dbg_en = 1'b0;
        tick();
        check("exit", 32'({dmode, halt}), 32'h0);
        $display("TB: debug entry done");
    endtask : t_debug
    task automatic close_out();
        $display("TB: checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    initial begin
        #20000;
        miscompares++;
        close_out();
    end
    initial begin
        {masked, dmatch, imatch, nmi_trap, mask_trap, dbg_en, dbg_exit, nr_clr} = 8'h00;
        {dea, dnpc, ipc, bpc} = 128'h0;
        machine_state_reg = 32'h0000_0002;
        stall = 4'h0;
        do_reset(1'b1);
        do_reset(1'b0);
        t_data();
        t_insn_masked();
        t_mask_ext();
        t_nmi();
        t_debug();
        close_out();
    end
endmodule : brk_exception_unit_tb
`default_nettype wire
